// ---- agc_defines.vh ----
// register map, field positions, reset values and codes of the receive gain control
// assumes a 32-bit AHB-Lite slave where a register index maps to byte address index*4
`ifndef AGC_DEFINES_VH
`define AGC_DEFINES_VH

// register indices and their byte addresses
`define IDX_GAIN_LIMIT_TARGET_CFG 16'hDF17
`define IDX_GAIN_ORDER_CARRIER_CFG 16'hDF18
`define IDX_GAIN_STATUS           16'hDF30
`define ADDR_GAIN_LIMIT_TARGET_CFG {14'h0000, `IDX_GAIN_LIMIT_TARGET_CFG, 2'h0}
`define ADDR_GAIN_ORDER_CARRIER_CFG {14'h0000, `IDX_GAIN_ORDER_CARRIER_CFG, 2'h0}
`define ADDR_GAIN_STATUS          {14'h0000, `IDX_GAIN_STATUS, 2'h0}

// register selector codes
`define SEL_NONE   2'h0
`define SEL_LIMIT  2'h1
`define SEL_ORDER  2'h2
`define SEL_STATUS 2'h3

// gain_limit_target_cfg fields
`define DIG_CAP_MSB    7
`define DIG_CAP_LSB    6
`define FRONT_CAP_MSB  5
`define FRONT_CAP_LSB  3
`define TARGET_MSB     2
`define TARGET_LSB     0
`define LIMIT_RESET    8'h03

// gain_order_carrier_cfg fields (bit 7 unused, reads zero)
`define ORDER_BIT      6
`define REL_THR_MSB    5
`define REL_THR_LSB    4
`define ABS_THR_MSB    3
`define ABS_THR_LSB    0
`define ORDER_RESET    7'h40
`define ORDER_WMASK    8'h7F

// carrier sense codes
`define CS_ABS_OFF     4'h8
`define CS_REL_OFF     2'h0
`define CS_REL_DB_1    8'h06
`define CS_REL_DB_2    8'h0A
`define CS_REL_DB_3    8'h0E
`define CS_REF_RESET   8'hFF

// htrans bit set for nonsequential and sequential transfers
`define HTRANS_ACTIVE_BIT 1

`endif

// ---- agc_monitor.sv ----
// checker for the receive gain control: register shadow, gain limits, carrier sense
// assumes it is bound to rx_gain_control and sees only its ports
`timescale 1ns/10ps
`include "agc_defines.vh"

module agc_monitor (
    // clock and reset
    input wire        hclk,
    input wire        hresetn,
    // bus
    input wire        hsel,
    input wire [31:0] haddr,
    input wire [1:0]  htrans,
    input wire        hwrite,
    input wire        hready,
    input wire [31:0] hwdata,
    input wire [31:0] hrdata,
    // receive side
    input wire        rx_active,
    input wire        sample_valid,
    input wire [2:0]  digital_variable_gain_stage,
    input wire [1:0]  first_stage_atten,
    input wire [1:0]  second_low_noise_stage,
    input wire        carrier_sense
);
    reg        ph_q, wr_q;
    reg [31:0] adr_q;
    reg [7:0]  lim_q, ord_q;
    reg [1:0]  up;
    default clocking @(posedge hclk); endclocking
    default disable iff (!hresetn);
    // shadow of both config registers and age since reset
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ph_q  <= 1'b0;
            wr_q  <= 1'b0;
            adr_q <= 32'h00000000;
            lim_q <= `LIMIT_RESET;
            ord_q <= {1'b0, `ORDER_RESET};
            up    <= 2'h0;
        end else begin
            ph_q  <= hsel && hready && htrans[1];
            wr_q  <= hwrite;
            adr_q <= haddr;
            if (up != 2'h3)
                up <= up + 2'h1;
            if (ph_q && wr_q && adr_q == `ADDR_GAIN_LIMIT_TARGET_CFG)
                lim_q <= hwdata[7:0];
            if (ph_q && wr_q && adr_q == `ADDR_GAIN_ORDER_CARRIER_CFG)
                ord_q <= hwdata[7:0] & `ORDER_WMASK;
        end
    end
    // gains forced to the capped maximum while idle
    property p_dig_cap;
        up == 2'h3 && !rx_active && $past(!rx_active) && $past(!rx_active, 2) && $stable(lim_q)
            |-> digital_variable_gain_stage == 3'h7 - lim_q[7:6];
    endproperty
    a_dig_cap: assert property (p_dig_cap) else $error("digital gain off cap");
    property p_front_cap;
        up == 2'h3 && !rx_active && $past(!rx_active, 2) && lim_q[5:3] == 3'h0 && $stable(lim_q)
            |-> first_stage_atten == 2'h0 && second_low_noise_stage == 2'h0;
    endproperty
    a_front_cap: assert property (p_front_cap) else $error("front gain not max");
    // carrier sense only after a sample and never while idle
    property p_cs_off;
        !rx_active ##1 !rx_active |-> !carrier_sense;
    endproperty
    a_cs_off: assert property (p_cs_off) else $error("sense high while idle");
    property p_cs_cause;
        $rose(carrier_sense) |-> $past(sample_valid) || $past(sample_valid, 2);
    endproperty
    a_cs_cause: assert property (p_cs_cause) else $error("sense rose with no sample");
    property p_abs_off;
        ord_q[5:0] == 6'h08 && $past(ord_q) == ord_q && $past(ord_q, 2) == ord_q
            |-> !$rose(carrier_sense);
    endproperty
    a_abs_off: assert property (p_abs_off) else $error("sense with both off");
    // reduction order of the two front stages
    property p_order_lo;
        rx_active && $past(rx_active) && !ord_q[6] && first_stage_atten > $past(first_stage_atten)
            |-> second_low_noise_stage == 2'h3;
    endproperty
    a_order_lo: assert property (p_order_lo) else $error("first stage cut early");
    property p_order_hi;
        rx_active && $past(rx_active) && ord_q[6] && second_low_noise_stage >
            $past(second_low_noise_stage) |-> first_stage_atten == 2'h3;
    endproperty
    a_order_hi: assert property (p_order_hi) else $error("second stage cut early");
    property p_rd_limit;
        ph_q && !wr_q && adr_q == `ADDR_GAIN_LIMIT_TARGET_CFG |-> hrdata == {24'h000000, lim_q};
    endproperty
    a_rd_limit: assert property (p_rd_limit) else $error("limit read wrong");
    // main scenarios reached
    c_cs_rise: cover property ($rose(carrier_sense));
    c_front_full: cover property (first_stage_atten == 2'h3 && second_low_noise_stage == 2'h3);
    c_order_lo: cover property (!ord_q[6] && rx_active && first_stage_atten != 2'h0);
endmodule

bind rx_gain_control agc_monitor u_mon (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite,
    .hready, .hwdata, .hrdata, .rx_active, .sample_valid, .digital_variable_gain_stage,
    .first_stage_atten, .second_low_noise_stage, .carrier_sense);

// ---- cs_detect.v ----
// carrier sense decision from absolute and relative signal strength thresholds
// assumes rssi samples arrive on the system clock with a one-cycle valid pulse
`timescale 1ns/10ps
`include "agc_defines.vh"

module cs_detect (
    // clock and reset
    input  wire       hclk,
    input  wire       hresetn,
    // receiver side
    input  wire       rx_active,
    input  wire       sample_valid,
    input  wire [7:0] rssi_db,
    // configuration
    input  wire [7:0] target_db,
    input  wire [3:0] abs_thr,
    input  wire [1:0] rel_thr,
    // decision
    output reg        carrier_sense
);

    reg  [7:0] ref_reg;

    // relative step size in dB
    function [7:0] rel_db;
        input [1:0] code;
        begin
            if (code == 2'h1)
                rel_db = `CS_REL_DB_1;
            else if (code == 2'h2)
                rel_db = `CS_REL_DB_2;
            else
                rel_db = `CS_REL_DB_3;
        end
    endfunction

    // absolute level is target plus a signed 1 dB offset
    wire              abs_on  = (abs_thr != `CS_ABS_OFF);
    wire signed [9:0] abs_lvl = $signed({2'h0, target_db})
                              + $signed({{6{abs_thr[3]}}, abs_thr});
    wire              abs_hit = abs_on && ($signed({2'h0, rssi_db}) >= abs_lvl);
    wire              rel_on  = (rel_thr != `CS_REL_OFF);
    wire [8:0]        rel_lvl = {1'b0, ref_reg} + {1'b0, rel_db(rel_thr)};
    wire              rel_hit = rel_on && ({1'b0, rssi_db} >= rel_lvl);

    // reference follows the floor, creeps up slowly, holds during a rise
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ref_reg       <= `CS_REF_RESET;
            carrier_sense <= 1'b0;
        end else if (!rx_active) begin
            ref_reg       <= `CS_REF_RESET;
            carrier_sense <= 1'b0;
        end else if (sample_valid) begin
            carrier_sense <= abs_hit | rel_hit;
            if (rssi_db < ref_reg)
                ref_reg <= rssi_db;
            else if (!rel_hit && ref_reg != `CS_REF_RESET)
                ref_reg <= ref_reg + 8'h01;
        end
    end

endmodule

// ---- fe_model.sv ----
// front-end model: amplitude and rssi samples from a stimulus level
// assumes gain codes come from the gain control on the same clock
`timescale 1ns/10ps

module fe_model (
    // clock
    input  wire       hclk,
    // stimulus
    input  wire       req,
    input  wire [7:0] level_db,
    // gain settings
    input  wire [2:0] dig,
    input  wire [1:0] s1,
    input  wire [1:0] s2,
    // samples
    output reg        sample_valid,
    output reg  [7:0] amp_db,
    output reg  [7:0] rssi_db
);
    // start idle
    initial begin
        sample_valid = 1'b0;
        amp_db       = 8'h00;
        rssi_db      = 8'h00;
    end
    // one sample per request; data lines toggle while not valid
    always @(posedge hclk) begin
        sample_valid <= req;
        amp_db       <= req ? level_db + dig - 8'h07 - s1 * 8'h06 - s2 * 8'h03 : ~amp_db;
        rssi_db      <= req ? level_db : ~rssi_db;
    end
endmodule

// ---- rx_gain_control.v ----
// receive gain control: config registers on AHB-Lite, gain stepping, carrier sense
// assumes amplitude and rssi samples come from the receive datapath on hclk
//
// The AHB-Lite interface to the registers is this design's own decision.
`timescale 1ns/10ps
`include "agc_defines.vh"

// Functional notes
// - digital gain cap code removes zero to three highest digital gain settings
// - front gain cap limits combined front stage gain, down to 17.1 dB below max
// - amplitude target code selects 24 to 42 dB, reset 33 dB
// - order bit 1 reduces first stage first; 0 drains second stage first
// - relative threshold 6/10/14 dB rise asserts carrier sense; code 00 disables
// - absolute threshold is signed 1 dB offset around the amplitude target
// - absolute code 1000 disables absolute detection entirely
// - carrier sense is exposed as a signal for other receiver logic
module rx_gain_control #(
    parameter [2:0] DIG_MAX        = 3'h7,
    parameter [1:0] S1_MAX         = 2'h3,
    parameter [1:0] S2_MAX         = 2'h3,
    parameter [7:0] S1_STEP_DT     = 8'h3C,
    parameter [7:0] S2_STEP_DT     = 8'h1E,
    parameter [7:0] HYST_DB        = 8'h02,
    parameter [4:0] SETTLE_SAMPLES = 5'h10
) (
    // clock and reset
    input  wire        hclk,
    input  wire        hresetn,
    // ahb-lite slave
    input  wire        hsel,
    input  wire [31:0] haddr,
    input  wire [1:0]  htrans,
    input  wire        hwrite,
    input  wire [2:0]  hsize,
    input  wire        hready,
    input  wire [31:0] hwdata,
    output reg  [31:0] hrdata,
    output wire        hreadyout,
    output wire        hresp,
    // receive datapath
    input  wire        rx_active,
    input  wire        sample_valid,
    input  wire [7:0]  amp_db,
    input  wire [7:0]  rssi_db,
    // gain stage controls
    output reg  [2:0]  digital_variable_gain_stage,
    output reg  [1:0]  first_stage_atten,
    output reg  [1:0]  second_low_noise_stage,
    output wire        carrier_sense
);

    localparam [1:0] ST_IDLE    = 2'h0;
    localparam [1:0] ST_SETTLE  = 2'h1;
    localparam [1:0] ST_MEASURE = 2'h2;

    reg  [7:0]  limit_reg;
    reg  [6:0]  order_reg;
    reg  [1:0]  wr_sel_reg;
    reg  [1:0]  state_reg;
    reg  [1:0]  state_next;
    reg  [4:0]  settle_reg;
    reg  [4:0]  settle_next;
    reg  [2:0]  dig_next;
    reg  [1:0]  s1_next;
    reg  [1:0]  s2_next;
    reg  [31:0] rd_next;

    // register address decode, used for both read and write phases
    function [1:0] reg_sel;
        input [31:0] addr;
        begin
            if (addr == `ADDR_GAIN_LIMIT_TARGET_CFG)
                reg_sel = `SEL_LIMIT;
            else if (addr == `ADDR_GAIN_ORDER_CARRIER_CFG)
                reg_sel = `SEL_ORDER;
            else if (addr == `ADDR_GAIN_STATUS)
                reg_sel = `SEL_STATUS;
            else
                reg_sel = `SEL_NONE;
        end
    endfunction

    // amplitude target code to dB
    function [7:0] target_db_of;
        input [2:0] code;
        begin
            case (code)
                3'h0:    target_db_of = 8'h18;
                3'h1:    target_db_of = 8'h1B;
                3'h2:    target_db_of = 8'h1E;
                3'h3:    target_db_of = 8'h21;
                3'h4:    target_db_of = 8'h24;
                3'h5:    target_db_of = 8'h26;
                3'h6:    target_db_of = 8'h28;
                default: target_db_of = 8'h2A;
            endcase
        end
    endfunction

    // front gain cap code to least attenuation, tenths of dB
    function [7:0] cap_att_of;
        input [2:0] code;
        begin
            case (code)
                3'h0:    cap_att_of = 8'h00;
                3'h1:    cap_att_of = 8'h1A;
                3'h2:    cap_att_of = 8'h3D;
                3'h3:    cap_att_of = 8'h4A;
                3'h4:    cap_att_of = 8'h5C;
                3'h5:    cap_att_of = 8'h73;
                3'h6:    cap_att_of = 8'h92;
                default: cap_att_of = 8'hAB;
            endcase
        end
    endfunction

    // combined front attenuation, tenths of dB
    function [9:0] front_att;
        input [1:0] s1;
        input [1:0] s2;
        begin
            front_att = s1 * S1_STEP_DT + s2 * S2_STEP_DT;
        end
    endfunction

    // least front attenuation that honours the cap, cutting in the selected order
    function [3:0] capped_front;
        input [9:0] cap;
        input       order;
        integer     n;
        reg   [1:0] a;
        reg   [1:0] b;
        begin
            a = 2'h0;
            b = 2'h0;
            // one cut per pass; both stages are full after S1_MAX + S2_MAX passes
            for (n = 0; n < S1_MAX + S2_MAX; n = n + 1) begin
                if (front_att(a, b) < cap) begin
                    if (order) begin
                        if (a < S1_MAX)
                            a = a + 2'h1;
                        else if (b < S2_MAX)
                            b = b + 2'h1;
                    end else begin
                        if (b < S2_MAX)
                            b = b + 2'h1;
                        else if (a < S1_MAX)
                            a = a + 2'h1;
                    end
                end
            end
            capped_front = {a, b};
        end
    endfunction

    // configuration fields
    wire [1:0] digital_gain_cap      = limit_reg[`DIG_CAP_MSB:`DIG_CAP_LSB];
    wire [2:0] front_gain_cap        = limit_reg[`FRONT_CAP_MSB:`FRONT_CAP_LSB];
    wire [2:0] amplitude_target      = limit_reg[`TARGET_MSB:`TARGET_LSB];
    wire       gain_reduce_order     = order_reg[`ORDER_BIT];
    wire [1:0] cs_relative_threshold = order_reg[`REL_THR_MSB:`REL_THR_LSB];
    wire [3:0] cs_absolute_threshold = order_reg[`ABS_THR_MSB:`ABS_THR_LSB];

    wire [1:0] addr_sel = reg_sel(haddr);
    wire       addr_hit = hsel && hready && htrans[`HTRANS_ACTIVE_BIT];

    // every transfer completes in one data phase with OKAY
    assign hreadyout = 1'b1;
    assign hresp     = 1'b0;

    // register writes land at the end of the data phase
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_sel_reg <= `SEL_NONE;
            limit_reg  <= `LIMIT_RESET;
            order_reg  <= `ORDER_RESET;
        end else begin
            wr_sel_reg <= (addr_hit && hwrite) ? addr_sel : `SEL_NONE;
            if (wr_sel_reg == `SEL_LIMIT)
                limit_reg <= hwdata[7:0];
            else if (wr_sel_reg == `SEL_ORDER)
                order_reg <= hwdata[6:0];
        end
    end

    // read data, forwarding a write still in its data phase
    always @* begin
        rd_next = 32'h00000000;
        if (addr_sel == `SEL_LIMIT)
            rd_next[7:0] = (wr_sel_reg == `SEL_LIMIT) ? hwdata[7:0] : limit_reg;
        else if (addr_sel == `SEL_ORDER)
            rd_next[7:0] = (wr_sel_reg == `SEL_ORDER) ? (hwdata[7:0] & `ORDER_WMASK)
                                                      : {1'b0, order_reg};
        else if (addr_sel == `SEL_STATUS)
            rd_next[7:0] = {carrier_sense, digital_variable_gain_stage,
                            first_stage_atten, second_low_noise_stage};
    end

    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn)
            hrdata <= 32'h00000000;
        else if (addr_hit && !hwrite)
            hrdata <= rd_next;
    end

    // gain decision terms
    wire [7:0]        target_db = target_db_of(amplitude_target);
    wire signed [9:0] amp_err   = $signed({2'h0, amp_db}) - $signed({2'h0, target_db});
    wire              too_high  = amp_err > $signed({2'h0, HYST_DB});
    wire              too_low   = amp_err < -$signed({2'h0, HYST_DB});
    wire [2:0]        dig_lim   = DIG_MAX - {1'b0, digital_gain_cap};
    wire [9:0]        cap_att   = {2'h0, cap_att_of(front_gain_cap)};
    wire [1:0]        s1        = first_stage_atten;
    wire [1:0]        s2        = second_low_noise_stage;
    wire [9:0]        att_now   = front_att(s1, s2);
    wire              can_cut   = (s1 < S1_MAX) || (s2 < S2_MAX);
    wire              s1_back   = (s1 != 2'h0) && (front_att(s1 - 2'h1, s2) >= cap_att);
    wire              s2_back   = (s2 != 2'h0) && (front_att(s1, s2 - 2'h1) >= cap_att);
    // idle front setting: highest gain the cap allows, so the cap holds even before a sample
    wire [3:0]        front_floor = capped_front(cap_att, gain_reduce_order);

    // next gains and state
    always @* begin
        state_next  = state_reg;
        settle_next = settle_reg;
        dig_next    = digital_variable_gain_stage;
        s1_next     = s1;
        s2_next     = s2;
        case (state_reg)
            ST_IDLE: begin
                dig_next = dig_lim;
                s1_next  = front_floor[3:2];
                s2_next  = front_floor[1:0];
                if (rx_active)
                    state_next = ST_MEASURE;
            end
            ST_SETTLE: begin
                if (sample_valid) begin
                    settle_next = settle_reg - 5'h01;
                    if (settle_reg == 5'h01)
                        state_next = ST_MEASURE;
                end
            end
            default: begin
                if (sample_valid) begin
                    if (digital_variable_gain_stage > dig_lim) begin
                        dig_next = dig_lim;
                    end else if (att_now < cap_att || (too_high && can_cut)) begin
                        if (gain_reduce_order) begin
                            if (s1 < S1_MAX)
                                s1_next = s1 + 2'h1;
                            else
                                s2_next = s2 + 2'h1;
                        end else begin
                            if (s2 < S2_MAX)
                                s2_next = s2 + 2'h1;
                            else
                                s1_next = s1 + 2'h1;
                        end
                    end else if (too_high && digital_variable_gain_stage != 3'h0) begin
                        dig_next = digital_variable_gain_stage - 3'h1;
                    end else if (too_low && digital_variable_gain_stage < dig_lim) begin
                        dig_next = digital_variable_gain_stage + 3'h1;
                    end else if (too_low) begin
                        // restore front gain in reverse order, never above the cap
                        if (gain_reduce_order ? s2_back : !s1_back && s2_back)
                            s2_next = s2 - 2'h1;
                        else if (s1_back)
                            s1_next = s1 - 2'h1;
                    end
                    if (dig_next != digital_variable_gain_stage || s1_next != s1
                        || s2_next != s2) begin
                        state_next  = ST_SETTLE;
                        settle_next = SETTLE_SAMPLES;
                    end
                end
            end
        endcase
        if (!rx_active)
            state_next = ST_IDLE;
    end

    // gain and state registers
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            state_reg                   <= ST_IDLE;
            settle_reg                  <= 5'h00;
            digital_variable_gain_stage <= 3'h0;
            first_stage_atten           <= 2'h0;
            second_low_noise_stage      <= 2'h0;
        end else begin
            state_reg                   <= state_next;
            settle_reg                  <= settle_next;
            digital_variable_gain_stage <= dig_next;
            first_stage_atten           <= s1_next;
            second_low_noise_stage      <= s2_next;
        end
    end

    // carrier sense, visible to the demodulator loops and in status
    cs_detect u_cs_detect (
        .hclk          (hclk),
        .hresetn       (hresetn),
        .rx_active     (rx_active),
        .sample_valid  (sample_valid),
        .rssi_db       (rssi_db),
        .target_db     (target_db),
        .abs_thr       (cs_absolute_threshold),
        .rel_thr       (cs_relative_threshold),
        .carrier_sense (carrier_sense)
    );

endmodule

// ---- tb_top.sv ----
// self-checking bench for rx_gain_control with a front-end model
// assumes one slave whose hreadyout is the bus ready
`timescale 1ns/10ps
`include "agc_defines.vh"

module tb_top;
    reg         hclk, hresetn, hsel, hwrite, rx_active, req;
    reg  [1:0]  htrans;
    reg  [2:0]  hsize;
    reg  [31:0] haddr, hwdata, rd;
    reg  [7:0]  level_db;
    wire [31:0] hrdata;
    wire        hreadyout, sample_valid, carrier_sense;
    wire [7:0]  amp_db, rssi_db;
    wire [2:0]  dig;
    wire [1:0]  s1, s2;
    integer     miscompares, checks_done, seed, i, k;
    integer     tdb [0:7];
    rx_gain_control uut (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize,
        .hready(hreadyout), .hwdata, .hrdata, .hreadyout, .hresp(), .rx_active,
        .sample_valid, .amp_db, .rssi_db, .digital_variable_gain_stage(dig),
        .first_stage_atten(s1), .second_low_noise_stage(s2), .carrier_sense);
    fe_model fe (.hclk, .req, .level_db, .dig, .s1, .s2, .sample_valid, .amp_db, .rssi_db);
    // clock
    initial begin
        hclk = 1'b0;
        forever #2.5 hclk = ~hclk;
    end
    // compare and count
    task chk(input [31:0] seen, input [31:0] exp);
        begin
            checks_done = checks_done + 1;
            if (seen !== exp) begin
                miscompares = miscompares + 1;
                $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
            end
        end
    endtask
    // verdict and end of run
    task close_out;
        begin
            if (miscompares == 0 && checks_done > 0)
                $display("Testbench passed");
            else
                $display("Testbench failed");
            $finish;
        end
    endtask
    // one single ahb transfer, read data left in rd
    task bus(input w, input [31:0] a, input [31:0] d);
        begin
            hsel   <= 1'b1;
            haddr  <= a;
            hwrite <= w;
            htrans <= 2'h2;
            @(posedge hclk);
            while (hreadyout !== 1'b1)
                @(posedge hclk);
            htrans <= 2'h0;
            hsel   <= 1'b0;
            hwdata <= d;
            @(posedge hclk);
            while (hreadyout !== 1'b1)
                @(posedge hclk);
            rd = hrdata;
        end
    endtask
    // one front-end sample, carrier sense compared unless e is negative
    task smp(input integer lvl, input integer e);
        begin
            level_db <= lvl[7:0];
            req      <= 1'b1;
            @(posedge hclk);
            req <= 1'b0;
            repeat (2) @(posedge hclk);
            @(negedge hclk);
            if (e >= 0)
                chk({31'h0, carrier_sense}, e);
            @(posedge hclk);
        end
    endtask
    // receiver off then on again
    task rxon;
        begin
            rx_active <= 1'b0;
            repeat (2) @(posedge hclk);
            rx_active <= 1'b1;
            @(posedge hclk);
        end
    endtask
    // watchdog
    initial begin
        #100000;
        miscompares = miscompares + 1;
        close_out;
    end
    // main sequence
    initial begin
        seed = 32'h9230;
        miscompares = 0;
        checks_done = 0;
        {hresetn, hsel, hwrite, rx_active, req, htrans, haddr, hwdata, level_db} = 0;
        hsize = 3'h2;
        tdb = '{24, 27, 30, 33, 36, 38, 40, 42};
        repeat (2) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        // reset values, read-only bit, unmapped place, random read back
        bus(0, `ADDR_GAIN_LIMIT_TARGET_CFG, 0); chk(rd, 32'h03);
        bus(0, `ADDR_GAIN_ORDER_CARRIER_CFG, 0); chk(rd, 32'h40);
        bus(1, `ADDR_GAIN_ORDER_CARRIER_CFG, 32'hFFFFFFFF);
        bus(0, `ADDR_GAIN_ORDER_CARRIER_CFG, 0); chk(rd, 32'h7F);
        bus(1, 32'h00037D00, 32'hFF);
        bus(0, 32'h00037D00, 0); chk(rd, 32'h00);
        bus(0, `ADDR_GAIN_LIMIT_TARGET_CFG, 0); chk(rd, 32'h03);
        for (i = 0; i < 4; i = i + 1) begin
            k = $random(seed);
            bus(1, `ADDR_GAIN_LIMIT_TARGET_CFG, k);
            bus(0, `ADDR_GAIN_LIMIT_TARGET_CFG, 0); chk(rd, k & 32'hFF);
        end
        // caps while idle
        for (i = 0; i < 8; i = i + 1) begin
            bus(1, `ADDR_GAIN_LIMIT_TARGET_CFG, (i % 4) * 64 + i * 8 + 3);
            repeat (3) @(posedge hclk);
            chk(dig, 7 - i % 4);
            chk(s1 * 6 + s2 * 3 == 0, i == 0);
        end
        // absolute threshold, every code, random target
        for (i = 0; i < 16; i = i + 1) begin
            k = $random(seed) & 7;
            bus(1, `ADDR_GAIN_LIMIT_TARGET_CFG, k);
            bus(1, `ADDR_GAIN_ORDER_CARRIER_CFG, 64 + i);
            rxon;
            smp(tdb[k] + ((i > 7) ? i - 16 : i) - 1, 0);
            smp(tdb[k] + ((i > 7) ? i - 16 : i), i != 8);
        end
        // relative threshold, every code
        for (i = 0; i < 4; i = i + 1) begin
            k = (i == 0) ? 0 : 2 + 4 * i;
            bus(1, `ADDR_GAIN_ORDER_CARRIER_CFG, 64 + i * 16 + 8);
            rxon;
            smp(20, -1);
            smp(19 + k, 0);
            smp(23 + k, i != 0);
        end
        // both criteria on
        bus(1, `ADDR_GAIN_LIMIT_TARGET_CFG, 3);
        bus(1, `ADDR_GAIN_ORDER_CARRIER_CFG, 64 + 16);
        rxon;
        smp(33, 1);
        smp(20, 0);
        // strong signal, both reduction orders
        for (i = 0; i < 2; i = i + 1) begin
            bus(1, `ADDR_GAIN_ORDER_CARRIER_CFG, 8 + 64 * (1 - i));
            rxon;
            k = 0;
            repeat (200) begin
                smp(63, -1);
                if (k == 0 && (s1 != 2'h0 || s2 != 2'h0)) begin
                    k = 1;
                    chk(s2 == 2'h0, 1 - i);
                end
            end
            chk({s1, s2}, 4'hF);
            bus(0, `ADDR_GAIN_STATUS, 0); chk(rd, {24'h0, carrier_sense, dig, s1, s2});
        end
        close_out;
    end
endmodule
